// ### logic/pin_route_state_ramp_spread_regs.sv
// register bank for pin routing, power state report and ramp spread control
`timescale 1ns/100ps
`default_nettype none
module pin_route_state_ramp_spread_regs
    import pin_route_pkg::*;
#(
    // arbitrary neutral identification value
    parameter logic [7:0] SILICON_CODE = 8'h5a
)
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // control port register access
    input  wire logic [7:0]  addr_in,
    input  wire logic        wr_en_in,
    input  wire logic        rd_en_in,
    input  wire logic [7:0]  wdata_in,
    output logic [7:0]       rdata_out,
    // device core status
    input  wire logic [1:0]  power_state_in,
    input  wire logic        left_automute_flag_in,
    input  wire logic        right_automute_flag_in,
    // output selectors and pin directions from neighbouring registers
    input  wire logic [11:0] outsel_in,
    input  wire logic [2:0]  pin_dir_out_in,
    input  wire logic [2:0]  func_val_in,
    // multipurpose pins
    input  wire logic [2:0]  pin_in,
    output logic [2:0]       pin_out,
    output logic [2:0]       pin_oe_out,
    // routed input functions
    output logic             spi_data_out,
    output logic             pin_reset_req_out,
    output logic             pin2_reset_exempt_out,
    // amplifier output stage
    output logic             driver_hiz_out,
    output logic             switching_en_out,
    // ramp clock control
    output logic [1:0]       ramp_phase_out,
    output logic             phase_sync_en_out,
    output logic             phase_sync_internal_out,
    output logic             phase_sync_pin_out,
    output logic             manual_mode_out,
    output logic             prediv2_sel_out,
    output logic             tri_spread_en_out,
    output logic             random_spread_en_out,
    output logic [3:0]       tri_ctrl_out,
    output logic [2:0]       dither_amount_out,
    output logic [7:0]       manual_ramp_divisor_out,
    output logic [3:0]       fall_step_size_out,
    output logic [3:0]       rise_step_size_out,
    output logic [1:0]       ramp_amplitude_setting_out
);
    // writable registers
    logic [7:0] route_q;
    logic [7:0] route_d;
    logic [7:0] levels_q;
    logic [7:0] levels_d;
    logic [7:0] invert_q;
    logic [7:0] invert_d;
    logic [7:0] phase_q;
    logic [7:0] phase_d;
    logic [7:0] spread_q;
    logic [7:0] spread_d;
    logic [7:0] shape_q;
    logic [7:0] shape_d;
    logic [7:0] divisor_q;
    logic [7:0] divisor_d;
    logic [7:0] steps_q;
    logic [7:0] steps_d;
    logic [7:0] amp_q;
    logic [7:0] amp_d;
    // status snapshots
    logic [7:0] state_q;
    logic [7:0] state_d;
    logic [7:0] automute_q;
    logic [7:0] automute_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    // mute and output stage
    logic       mute_low_input;
    logic       reset_low;
    logic       sync_pin;
    logic       hiz_q;
    logic       hiz_d;
    logic [2:0] pin_reset;

    pin_input_router u_router (
        .route_in              (route_q),
        .pin_level_in          (pin_in),
        .spi_data_out          (spi_data_out),
        .sync_out              (sync_pin),
        .reset_low_out         (reset_low),
        .mute_low_out          (mute_low_input),
        .pin2_reset_exempt_out (pin2_reset_exempt_out)
    );

    // routed reset clears pin drive, except pin2 when it is the reset source
    always_comb
    begin
        pin_reset    = {3{~reset_low}};
        pin_reset[2] = ~reset_low & ~pin2_reset_exempt_out;
    end

    pin_output_driver u_driver (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .levels_in    (levels_q[2:0]),
        .invert_in    (invert_q[2:0]),
        .oe_in        (pin_dir_out_in),
        .outsel_in    (outsel_in),
        .func_val_in  (func_val_in),
        .pin_reset_in (pin_reset),
        .pin_out      (pin_out),
        .pin_oe_out   (pin_oe_out)
    );

    // register writes; silicon code and status are not writable
    always_comb
    begin
        route_d   = route_q;
        levels_d  = levels_q;
        invert_d  = invert_q;
        phase_d   = phase_q;
        spread_d  = spread_q;
        shape_d   = shape_q;
        divisor_d = divisor_q;
        steps_d   = steps_q;
        amp_d     = amp_q;
        if (wr_en_in)
        begin
            unique case (addr_in)
                ADDR_ROUTE:     route_d   = wdata_in;
                ADDR_LEVELS:    levels_d  = wdata_in;
                ADDR_INVERT:    invert_d  = wdata_in;
                ADDR_PHASE:     phase_d   = wdata_in;
                ADDR_SPREAD:    spread_d  = wdata_in;
                ADDR_SHAPE:     shape_d   = wdata_in;
                ADDR_DIVISOR:   divisor_d = wdata_in;
                ADDR_STEPS:     steps_d   = wdata_in;
                ADDR_AMPLITUDE: amp_d     = wdata_in;
                default:        route_d   = route_q;
            endcase
        end
    end

    // status snapshots and output stage control
    always_comb
    begin
        state_d    = {6'h00, power_state_in};
        automute_d = {6'h00, right_automute_flag_in, left_automute_flag_in};
        hiz_d      = ~mute_low_input;
    end

    // read mux; reads have no side effects
    always_comb
    begin
        rdata_d = rdata_q;
        if (rd_en_in)
        begin
            unique case (addr_in)
                ADDR_ROUTE:     rdata_d = route_q;
                ADDR_LEVELS:    rdata_d = levels_q;
                ADDR_INVERT:    rdata_d = invert_q;
                ADDR_SILICON:   rdata_d = SILICON_CODE;
                ADDR_STATE:     rdata_d = state_q;
                ADDR_AUTOMUTE:  rdata_d = automute_q;
                ADDR_PHASE:     rdata_d = phase_q;
                ADDR_SPREAD:    rdata_d = spread_q;
                ADDR_SHAPE:     rdata_d = shape_q;
                ADDR_DIVISOR:   rdata_d = divisor_q;
                ADDR_STEPS:     rdata_d = steps_q;
                ADDR_AMPLITUDE: rdata_d = amp_q;
                default:        rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            route_q    <= RST_ROUTE;
            levels_q   <= RST_LEVELS;
            invert_q   <= RST_INVERT;
            phase_q    <= RST_PHASE;
            spread_q   <= RST_SPREAD;
            shape_q    <= RST_SHAPE;
            divisor_q  <= RST_DIVISOR;
            steps_q    <= RST_STEPS;
            amp_q      <= RST_AMPLITUDE;
            state_q    <= 8'h00;
            automute_q <= 8'h00;
            rdata_q    <= 8'h00;
            hiz_q      <= 1'b0;
        end
        else
        begin
            route_q    <= route_d;
            levels_q   <= levels_d;
            invert_q   <= invert_d;
            phase_q    <= phase_d;
            spread_q   <= spread_d;
            shape_q    <= shape_d;
            divisor_q  <= divisor_d;
            steps_q    <= steps_d;
            amp_q      <= amp_d;
            state_q    <= state_d;
            automute_q <= automute_d;
            rdata_q    <= rdata_d;
            hiz_q      <= hiz_d;
        end
    end

    assign rdata_out         = rdata_q;
    assign pin_reset_req_out = ~reset_low;
    assign driver_hiz_out    = hiz_q;
    assign switching_en_out  = ~hiz_q;

    // ramp phase and sync; phase must be set before play (host side)
    assign ramp_phase_out          = phase_q[PHASE_SEL_LSB +: 2];
    assign phase_sync_en_out       = phase_q[PHASE_SYNC_EN_BIT];
    assign phase_sync_internal_out = phase_q[PHASE_SYNC_SRC_BIT];
    assign phase_sync_pin_out      = phase_q[PHASE_SYNC_EN_BIT] & ~phase_q[PHASE_SYNC_SRC_BIT]
                                     & sync_pin;

    // spread spectrum controls; of the manual settings only the predivider select is gated by manual mode
    assign manual_mode_out      = spread_q[SPREAD_MANUAL_BIT];
    assign prediv2_sel_out      = spread_q[SPREAD_MANUAL_BIT] & spread_q[SPREAD_PREDIV_BIT];
    assign tri_spread_en_out    = spread_q[SPREAD_TRI_BIT];
    assign random_spread_en_out = spread_q[SPREAD_RDM_BIT];
    assign tri_ctrl_out         = shape_q[SHAPE_TRI_LSB +: 4];
    assign dither_amount_out    = shape_q[SHAPE_DITHER_LSB +: 3];
    assign manual_ramp_divisor_out    = divisor_q;
    assign fall_step_size_out         = steps_q[STEP_FALL_LSB +: 4];
    assign rise_step_size_out         = steps_q[STEP_RISE_LSB +: 4];
    assign ramp_amplitude_setting_out = amp_q[AMP_LSB +: 2];
endmodule : pin_route_state_ramp_spread_regs
`default_nettype wire

// ### logic/pin_route_pkg.sv
// package: register map, field positions, reset values and codes for the pin/ramp register bank
`default_nettype none
package pin_route_pkg;
    localparam logic [7:0] ADDR_ROUTE      = 8'h64;
    localparam logic [7:0] ADDR_LEVELS     = 8'h65;
    localparam logic [7:0] ADDR_INVERT     = 8'h66;
    localparam logic [7:0] ADDR_SILICON    = 8'h67;
    localparam logic [7:0] ADDR_STATE      = 8'h68;
    localparam logic [7:0] ADDR_AUTOMUTE   = 8'h69;
    localparam logic [7:0] ADDR_PHASE      = 8'h6a;
    localparam logic [7:0] ADDR_SPREAD     = 8'h6b;
    localparam logic [7:0] ADDR_SHAPE      = 8'h6c;
    localparam logic [7:0] ADDR_DIVISOR    = 8'h6d;
    localparam logic [7:0] ADDR_STEPS      = 8'h6e;
    localparam logic [7:0] ADDR_AMPLITUDE  = 8'h6f;
    localparam int         NUM_REGS        = 12;

    localparam logic [7:0] RST_ROUTE       = 8'h00;
    localparam logic [7:0] RST_LEVELS      = 8'h00;
    localparam logic [7:0] RST_INVERT      = 8'h00;
    localparam logic [7:0] RST_PHASE       = 8'h00;
    localparam logic [7:0] RST_SPREAD      = 8'h00;
    localparam logic [7:0] RST_SHAPE       = 8'h00;
    localparam logic [7:0] RST_DIVISOR     = 8'ha0;
    localparam logic [7:0] RST_STEPS       = 8'h11;
    localparam logic [7:0] RST_AMPLITUDE   = 8'h24;

    // route field positions (low bit)
    localparam int ROUTE_MISO_LSB  = 6;
    localparam int ROUTE_SYNC_LSB  = 4;
    localparam int ROUTE_RESET_LSB = 2;
    localparam int ROUTE_MUTE_LSB  = 0;
    localparam logic [1:0] ROUTE_NONE = 2'h0;
    localparam logic [1:0] ROUTE_PIN2 = 2'h3;

    localparam int PHASE_SYNC_EN_BIT  = 0;
    localparam int PHASE_SYNC_SRC_BIT = 1;
    localparam int PHASE_SEL_LSB      = 2;

    localparam int SPREAD_TRI_BIT    = 0;
    localparam int SPREAD_RDM_BIT    = 1;
    localparam int SPREAD_MANUAL_BIT = 4;
    localparam int SPREAD_PREDIV_BIT = 5;

    localparam int SHAPE_TRI_LSB    = 0;
    localparam int SHAPE_DITHER_LSB = 4;
    localparam int STEP_RISE_LSB    = 0;
    localparam int STEP_FALL_LSB    = 4;
    localparam int AMP_LSB          = 5;

    localparam logic [3:0] OUTSEL_USER = 4'h2;
    localparam int         NUM_PINS    = 3;
    localparam int         RAMP_BASE_HZ = 61440000;

    typedef enum logic [1:0] {
        PS_DEEP_SLEEP = 2'h0,
        PS_SLEEP      = 2'h1,
        PS_HIZ        = 2'h2,
        PS_PLAY       = 2'h3
    } power_state_t;

    // pin route field -> one-hot pin select, bit0 = pin0
    function automatic logic [2:0] route_decode(input logic [1:0] code);
        logic [2:0] sel;
        sel = 3'h0;
        unique case (code)
            2'h1: sel = 3'h1;
            2'h2: sel = 3'h2;
            2'h3: sel = 3'h4;
            default: sel = 3'h0;
        endcase
        return sel;
    endfunction : route_decode
endpackage : pin_route_pkg
`default_nettype wire

// ### logic/pin_input_router.sv
// input-function routing from multipurpose pins
`timescale 1ns/100ps
`default_nettype none
module pin_input_router
    import pin_route_pkg::*;
(
    // route field and pins
    input  wire logic [7:0] route_in,
    input  wire logic [2:0] pin_level_in,
    // routed functions; active-high ones 0 when unconnected, active-low ones 1
    output logic            spi_data_out,
    output logic            sync_out,
    output logic            reset_low_out,
    output logic            mute_low_out,
    output logic            pin2_reset_exempt_out
);
    logic [2:0] miso_sel;
    logic [2:0] sync_sel;
    logic [2:0] reset_sel;
    logic [2:0] mute_sel;

    always_comb
    begin
        miso_sel  = route_decode(route_in[ROUTE_MISO_LSB +: 2]);
        sync_sel  = route_decode(route_in[ROUTE_SYNC_LSB +: 2]);
        reset_sel = route_decode(route_in[ROUTE_RESET_LSB +: 2]);
        mute_sel  = route_decode(route_in[ROUTE_MUTE_LSB +: 2]);
        spi_data_out  = |(miso_sel & pin_level_in);
        sync_out      = |(sync_sel & pin_level_in);
        // unrouted active-low inputs read inactive (high)
        reset_low_out = (reset_sel == 3'h0) ? 1'b1 : |(reset_sel & pin_level_in);
        mute_low_out  = (mute_sel == 3'h0) ? 1'b1 : |(mute_sel & pin_level_in);
        pin2_reset_exempt_out = (route_in[ROUTE_RESET_LSB +: 2] == ROUTE_PIN2);
    end
endmodule : pin_input_router
`default_nettype wire

// ### logic/pin_output_driver.sv
// multipurpose pin output value, inversion and drive
`timescale 1ns/100ps
`default_nettype none
module pin_output_driver
    import pin_route_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // controls
    input  wire logic [2:0]  levels_in,
    input  wire logic [2:0]  invert_in,
    input  wire logic [2:0]  oe_in,
    input  wire logic [11:0] outsel_in,
    input  wire logic [2:0]  func_val_in,
    input  wire logic [2:0]  pin_reset_in,
    // pins
    output logic [2:0]       pin_out,
    output logic [2:0]       pin_oe_out
);
    logic [2:0] pin_d;
    logic [2:0] pin_q;
    logic [2:0] oe_d;
    logic [2:0] oe_q;

    always_comb
    begin
        for (int i = 0; i < NUM_PINS; i++)
        begin
            if (outsel_in[4*i +: 4] == OUTSEL_USER)
                pin_d[i] = levels_in[i] ^ invert_in[i];
            else
                pin_d[i] = func_val_in[i] ^ invert_in[i];
            oe_d[i] = oe_in[i] & ~pin_reset_in[i];
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            pin_q <= 3'h0;
            oe_q  <= 3'h0;
        end
        else
        begin
            pin_q <= pin_d;
            oe_q  <= oe_d;
        end
    end

    assign pin_out    = pin_q;
    assign pin_oe_out = oe_q;
endmodule : pin_output_driver
`default_nettype wire

// ### sim/pin_route_regs_properties.sv
// concurrent checks on the pin routing and ramp spread register bank
`timescale 1ns/100ps
`default_nettype none
module pin_route_regs_props
    import pin_route_pkg::*;
#(
    parameter logic [7:0] SILICON_CODE = 8'h5a
)
(
    // clock, reset and access port
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic [7:0]  addr_in,
    input wire logic        wr_en_in,
    input wire logic        rd_en_in,
    input wire logic [7:0]  wdata_in,
    input wire logic [7:0]  rdata_out,
    // pins and routed functions
    input wire logic [11:0] outsel_in,
    input wire logic [2:0]  pin_in,
    input wire logic [2:0]  pin_out,
    input wire logic        spi_data_out,
    input wire logic        pin2_reset_exempt_out,
    input wire logic        driver_hiz_out,
    input wire logic        switching_en_out,
    // ramp clock control
    input wire logic [1:0]  ramp_phase_out,
    input wire logic        phase_sync_en_out,
    input wire logic        phase_sync_internal_out,
    input wire logic        manual_mode_out,
    input wire logic        prediv2_sel_out,
    input wire logic        tri_spread_en_out,
    input wire logic        random_spread_en_out,
    input wire logic [7:0]  manual_ramp_divisor_out,
    input wire logic [3:0]  fall_step_size_out,
    input wire logic [3:0]  rise_step_size_out,
    input wire logic [1:0]  ramp_amplitude_setting_out
);
    logic [7:0] route_q, route_d, lev_q, lev_d, inv_q, inv_d;
    logic       mute_act;
    logic       spi_exp;

    // shadow copies of the routing, level and invert registers
    always_comb
    begin
        route_d = (wr_en_in && addr_in == ADDR_ROUTE) ? wdata_in : route_q;
        lev_d   = (wr_en_in && addr_in == ADDR_LEVELS) ? wdata_in : lev_q;
        inv_d   = (wr_en_in && addr_in == ADDR_INVERT) ? wdata_in : inv_q;
        if (rst_in)
        begin
            route_d = RST_ROUTE;
            lev_d   = RST_LEVELS;
            inv_d   = RST_INVERT;
        end
    end

    always_ff @(posedge clk_in)
    begin
        route_q <= route_d;
        lev_q   <= lev_d;
        inv_q   <= inv_d;
    end

    assign mute_act = route_q[1:0] != 2'h0 && !pin_in[route_q[1:0] - 2'h1];
    assign spi_exp  = route_q[7:6] != 2'h0 && pin_in[route_q[7:6] - 2'h1];

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    chk_phase_select:
        assert property (wr_en_in && addr_in == ADDR_PHASE |=>
            ramp_phase_out == $past(wdata_in[3:2])) else $error("ramp phase field wrong");
    chk_sync_bits:
        assert property (wr_en_in && addr_in == ADDR_PHASE |=>
            {phase_sync_internal_out, phase_sync_en_out} == $past(wdata_in[1:0]))
        else $error("phase sync bits wrong");
    chk_spread_mode:
        assert property (wr_en_in && addr_in == ADDR_SPREAD |=>
            manual_mode_out == $past(wdata_in[4]) && prediv2_sel_out == $past(wdata_in[5] & wdata_in[4])
            && {random_spread_en_out, tri_spread_en_out} == $past(wdata_in[1:0]))
        else $error("spread mode bits wrong");
    chk_divisor_field:
        assert property (wr_en_in && addr_in == ADDR_DIVISOR |=>
            manual_ramp_divisor_out == $past(wdata_in)) else $error("divisor wrong");
    chk_step_fields:
        assert property (wr_en_in && addr_in == ADDR_STEPS |=>
            {fall_step_size_out, rise_step_size_out} == $past(wdata_in)) else $error("steps wrong");
    chk_amp_field:
        assert property (wr_en_in && addr_in == ADDR_AMPLITUDE |=>
            ramp_amplitude_setting_out == $past(wdata_in[6:5])) else $error("amplitude wrong");
    chk_id_read:
        assert property (rd_en_in && addr_in == ADDR_SILICON |=> rdata_out == SILICON_CODE)
        else $error("identification read wrong");
    chk_mute_stage:
        assert property ($past(rst_in) == 1'b0 |->
            driver_hiz_out == $past(mute_act) && switching_en_out == !$past(mute_act))
        else $error("mute did not stop output stage");
    chk_spi_route:
        assert property (spi_data_out == spi_exp) else $error("data input route wrong");
    chk_pin2_exempt:
        assert property (pin2_reset_exempt_out == (route_q[3:2] == ROUTE_PIN2))
        else $error("pin2 exemption wrong");
    chk_pin0_drive:
        assert property (outsel_in[3:0] == OUTSEL_USER && route_q[3:2] == ROUTE_NONE |=>
            pin_out[0] == $past(lev_q[0] ^ inv_q[0])) else $error("pin0 level wrong");

    cov_manual_prediv: cover property (wr_en_in && addr_in == ADDR_SPREAD && wdata_in[5:4] == 2'h3);
    cov_mute_hiz: cover property (mute_act ##1 driver_hiz_out);
    cov_id_read: cover property (rd_en_in && addr_in == ADDR_SILICON);
endmodule : pin_route_regs_props

bind pin_route_state_ramp_spread_regs pin_route_regs_props #(
    .SILICON_CODE (SILICON_CODE)
) i_props (.*);
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the pin routing and ramp spread register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import pin_route_pkg::*;
;
    // arbitrary identification value
    localparam logic [7:0] CODE = 8'h3c;
    logic        clk_in = 1'b0, rst_in = 1'b1, wr_en_in = 1'b0, rd_en_in = 1'b0;
    logic [7:0]  addr_in = 8'h00, wdata_in = 8'h00, rdata_out, manual_ramp_divisor_out;
    logic [1:0]  power_state_in = 2'h0, ramp_phase_out, ramp_amplitude_setting_out;
    logic        left_automute_flag_in = 1'b0, right_automute_flag_in = 1'b0;
    logic [11:0] outsel_in = 12'h000;
    logic [2:0]  pin_dir_out_in = 3'h7, func_val_in = 3'h0, pin_in = 3'h0, pin_out, pin_oe_out;
    logic        spi_data_out, pin_reset_req_out, pin2_reset_exempt_out, driver_hiz_out;
    logic        switching_en_out, phase_sync_en_out, phase_sync_internal_out, phase_sync_pin_out;
    logic        manual_mode_out, prediv2_sel_out, tri_spread_en_out, random_spread_en_out;
    logic [3:0]  tri_ctrl_out, fall_step_size_out, rise_step_size_out;
    logic [2:0]  dither_amount_out, inv;
    logic [7:0]  pat [3] = '{8'ha5, 8'h5a, 8'h30};
    logic        rt;
    int          mismatches = 0, checks_done = 0;

    pin_route_state_ramp_spread_regs #(
        .SILICON_CODE (CODE)
    ) i_dut (.*);

    always #12.5 clk_in = ~clk_in;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_en_in <= 1'b1;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        addr_in  <= a;
        rd_en_in <= 1'b1;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        #1;
        chk(rdata_out, exp);
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : cyc

    // readback value with status inputs at zero; fresh selects reset values
    function automatic logic [7:0] exp_at(input logic [7:0] a, input logic [7:0] p, input bit fresh);
        if (a == 8'h67)
            return CODE;
        if (a == 8'h68 || a == 8'h69 || a == 8'h70)
            return 8'h00;
        if (!fresh)
            return p;
        case (a)
            8'h6d: return 8'ha0;
            8'h6e: return 8'h11;
            8'h6f: return 8'h24;
            default: return 8'h00;
        endcase
    endfunction : exp_at

    task automatic conclude();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    initial
    begin
        repeat (20000) @(posedge clk_in);
        mismatches++;
        conclude();
    end

    initial
    begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int a = 8'h64; a <= 8'h70; a++)
            rd(8'(a), exp_at(8'(a), 8'h00, 1'b1));
        $display("test reset_values done");
        foreach (pat[i])
        begin
            for (int a = 8'h64; a <= 8'h70; a++)
                wr(8'(a), pat[i]);
            for (int a = 8'h64; a <= 8'h70; a++)
                rd(8'(a), exp_at(8'(a), pat[i], 1'b0));
            chk(ramp_phase_out, pat[i][3:2]);
            chk({phase_sync_internal_out, phase_sync_en_out}, pat[i][1:0]);
            chk(prediv2_sel_out, pat[i][5] & pat[i][4]);
            chk(manual_mode_out, pat[i][4]);
            chk({random_spread_en_out, tri_spread_en_out}, pat[i][1:0]);
            chk({dither_amount_out, tri_ctrl_out}, pat[i][6:0]);
            chk(manual_ramp_divisor_out, pat[i]);
            chk({fall_step_size_out, rise_step_size_out}, pat[i]);
            chk(ramp_amplitude_setting_out, pat[i][6:5]);
        end
        $display("test field_access done");
        // second reset in mid-run must restore every reset value
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int a = 8'h64; a <= 8'h70; a++)
            rd(8'(a), exp_at(8'(a), 8'h00, 1'b1));
        $display("test mid_run_reset done");
        // phase and pin sync chosen before the core reports play
        wr(ADDR_PHASE, 8'h01);
        for (int s = 0; s < 4; s++)
        begin
            @(posedge clk_in);
            power_state_in         <= 2'(s);
            left_automute_flag_in  <= s[0];
            right_automute_flag_in <= s[1];
            cyc(2);
            rd(8'h68, 8'(s));
            rd(8'h69, 8'(s));
            rd(8'h69, 8'(s));
        end
        $display("test status_reports done");
        wr(ADDR_ROUTE, 8'h00);
        outsel_in <= 12'h222;
        for (int v = 0; v < 16; v++)
        begin
            inv = v[3] ? 3'h5 : 3'h2;
            wr(ADDR_LEVELS, {5'h1f, 3'(v)});
            wr(ADDR_INVERT, {5'h00, inv});
            cyc(2);
            chk(pin_out, 3'(v) ^ inv);
        end
        // other output function: level comes from the function, still inverted
        @(posedge clk_in);
        outsel_in   <= 12'h333;
        func_val_in <= 3'h3;
        cyc(2);
        chk(pin_out, 3'h6);
        $display("test pin_drive done");
        for (int c = 0; c < 4; c++)
            for (int lo = 0; lo < 2; lo++)
            begin
                wr(ADDR_ROUTE, 8'(c * 8'h55));
                inv = (c == 0) ? 3'h0 : 3'(1 << (c - 1));
                pin_in <= lo ? ~inv : inv;
                rt = (c != 0);
                cyc(2);
                chk(spi_data_out, rt & !lo[0]);
                chk(pin_reset_req_out, rt & lo[0]);
                chk(pin2_reset_exempt_out, c == 3);
                chk({driver_hiz_out, switching_en_out}, (rt & lo[0]) ? 8'h2 : 8'h1);
                chk(pin_oe_out, (rt & lo[0]) ? ((c == 3) ? 8'h4 : 8'h0) : 8'h7);
                chk(phase_sync_pin_out, rt & !lo[0]);
            end
        $display("test input_routing done");
        conclude();
    end
endmodule : tb_top
`default_nettype wire
